// *** rtl/brp_pkg.sv ***
package brp_pkg;
  // Register byte offsets on the APB port.
  localparam logic [7:0] ADDR_SRC      = 8'h00;
  localparam logic [7:0] ADDR_NETCMD   = 8'h04;
  localparam logic [7:0] ADDR_MODE     = 8'h08;
  localparam logic [7:0] ADDR_RELSEL   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  // Programmable input functions, each with a two-bit source field at 2*index.
  localparam int NUM_FN      = 5;
  localparam int FN_START    = 0;
  localparam int FN_PERMIT   = 1;
  localparam int FN_ILOCK    = 2;
  localparam int FN_RESET    = 3;
  localparam int FN_ADV      = 4;
  localparam int SRC_W       = 2;

  typedef enum logic [1:0] {
    SRC_CONTACT = 2'h0,
    SRC_IGNORE  = 2'h1,
    SRC_NET     = 2'h2
  } brp_src_type;

  typedef enum logic [1:0] {
    CTL_OFF  = 2'h0,
    CTL_HAND = 2'h1,
    CTL_AUTO = 2'h2
  } brp_ctl_type;

  // Network command register fields.
  localparam int NET_RELAY_ON  = 8;
  localparam int NET_RELAY_OFF = 9;
  localparam int NET_RELAY_ST  = 16;

  // Mode register fields.
  localparam int MODE_LINE     = 0;
  localparam int MODE_DRV_AUTO = 1;
  localparam int MODE_CTL_LSB  = 4;

  // Status register fields.
  localparam int ST_CONTACT_LSB = 0;
  localparam int ST_RELAY_LSB   = 8;
  localparam int ST_FLAG_LSB    = 16;

  // Relay selection: one five-bit code per relay.
  localparam int NUM_RELAY = 5;
  localparam int SEL_W     = 5;

  // Reset values.
  localparam logic [9:0]  SRC_RST    = 10'h000;
  localparam logic [4:0]  NET_RST    = 5'h00;
  localparam logic [24:0] RELSEL_RST = 25'h000_0000;

  // Relay function codes; any other code leaves the relay off.
  localparam logic [4:0] RF_READY      = 5'h01;
  localparam logic [4:0] RF_RUNNING    = 5'h02;
  localparam logic [4:0] RF_STARTED    = 5'h03;
  localparam logic [4:0] RF_LINE_SEL   = 5'h04;
  localparam logic [4:0] RF_LINE_RUN   = 5'h05;
  localparam logic [4:0] RF_LINE_FLT   = 5'h06;
  localparam logic [4:0] RF_LINE_OK    = 5'h07;
  localparam logic [4:0] RF_LINE_WARN  = 5'h08;
  localparam logic [4:0] RF_DRV_FLT    = 5'h09;
  localparam logic [4:0] RF_DRV_OK     = 5'h0A;
  localparam logic [4:0] RF_DRV_WARN   = 5'h0B;
  localparam logic [4:0] RF_OVERRIDE   = 5'h0C;
  localparam logic [4:0] RF_LINE_HAND  = 5'h0D;
  localparam logic [4:0] RF_LINE_OFF   = 5'h0E;
  localparam logic [4:0] RF_LINE_AUTO  = 5'h0F;
  localparam logic [4:0] RF_NET_CTRL   = 5'h10;
  localparam logic [4:0] RF_ANY_WARN   = 5'h11;
  localparam logic [4:0] RF_LINE_FW    = 5'h12;

  // Timing.
  localparam longint CLK_PERIOD_NS  = 4;
  localparam longint FLASH_HALF_MS  = 250;
  localparam longint FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint LOCK_MIN       = 3;
  localparam longint LOCK_CYC       = LOCK_MIN * 60 * 1000000000 / CLK_PERIOD_NS;
  localparam int     FLASH_W        = 26;
  localparam int     LOCK_W         = 36;

  typedef struct packed {
    logic reverse;
    logic smoke;
    logic adv_ovr;
    logic fault_reset;
    logic interlock;
    logic permit;
    logic start;
  } brp_contact_type;

  typedef struct packed {
    logic power_ok;
    logic overload_trip;
    logic line_warn;
    logic line_fault;
    logic drive_running;
    logic drive_warn;
    logic drive_fault;
  } brp_cond_type;

  typedef struct packed {
    logic drive_contactor;
    logic line_contactor;
    logic started_relay;
    logic led_green;
    logic led_red;
  } brp_drive_type;
endpackage : brp_pkg

// *** rtl/brp_relay_io.sv ***
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
// Functional notes
// - Inputs except smoke and reverse take contact, ignored or network source.
// - Ignored input does nothing for control but its contact is still reported.
// - Network source uses the network bit, contact still reported.
// - Start contact runs drive in drive auto, or line contactor in line auto.
// - Permissive open with start present flashes green and blocks running.
// - Open interlock lights red and drops both contactors and started relay.
// - Fault reset clears line fault; after overload it waits several minutes.
// - Second override contact selects advanced override; smoke selects fire mode.
// - Reverse contact selects reverse drive mode.
// - Function 1: interlocks closed and no fault in selected power mode.
// - Function 2: motor running from drive or line.
// - Function 3: start requested (start in auto, or line hand), interlocks closed, no system fault.
// - Function 4: line mode selected.
// - Function 5: motor running from line power.
// - Function 6 line fault or overload; function 7 its complement, off unpowered.
// - Function 8: line warning present.
// - Function 9 drive fault; function 10 healthy, drops on fault or power loss.
// - Function 11: drive warning present.
// - Function 12: smoke or advanced override selected.
// - Functions 13, 14, 15: line run in hand, line control off, line control auto.
// - Function 16 set by network ON, cleared by network OFF.
// - Function 17 any warning; function 18 line fault, overload or line warning.
// - Five programmable inputs, two fixed inputs, five programmable relays.
module brp_relay_io #(
  parameter logic [brp_pkg::FLASH_W-1:0] FLASH_CYC = brp_pkg::FLASH_W'(brp_pkg::FLASH_HALF_CYC),
  parameter logic [brp_pkg::LOCK_W-1:0]  LOCK_CYC  = brp_pkg::LOCK_W'(brp_pkg::LOCK_CYC)
) (
  // Clock, reset, enable.
  input  wire logic                    I_CLK_SYS,
  input  wire logic                    I_NRST,
  input  wire logic                    I_CE,
  // APB slave.
  input  wire logic                    I_PSEL,
  input  wire logic                    I_PENABLE,
  input  wire logic                    I_PWRITE,
  input  wire logic [7:0]              I_PADDR,
  input  wire logic [31:0]             I_PWDATA,
  output logic      [31:0]             O_PRDATA,
  output logic                         O_PREADY,
  output logic                         O_PSLVERR,
  // Contact inputs and plant conditions, asynchronous.
  input  wire brp_pkg::brp_contact_type I_CONTACT,
  input  wire brp_pkg::brp_cond_type    I_COND,
  // Contactor, relay and indicator drive.
  output brp_pkg::brp_drive_type        O_DRIVE,
  output logic                         O_DRIVE_START,
  output logic                         O_FIRE_MODE,
  output logic                         O_ADV_MODE,
  output logic                         O_REVERSE_MODE,
  output logic [brp_pkg::NUM_RELAY-1:0] O_RELAY
);

  typedef struct packed {
    brp_pkg::brp_contact_type         c_meta;
    brp_pkg::brp_contact_type         c_sync;
    brp_pkg::brp_cond_type            k_meta;
    brp_pkg::brp_cond_type            k_sync;
    logic [9:0]                       src;
    logic [4:0]                       net;
    logic                             comm_relay;
    logic                             line_mode;
    logic                             drive_auto;
    brp_pkg::brp_ctl_type             ctl;
    logic [24:0]                      relsel;
    logic                             line_flt;
    logic                             ovld;
    logic [brp_pkg::LOCK_W-1:0]       lock_cnt;
    logic [brp_pkg::FLASH_W-1:0]      flash_cnt;
    logic                             flash;
    logic                             reset_prev;
    logic [31:0]                      prdata;
    logic                             pslverr;
    brp_pkg::brp_drive_type           drv;
    logic                             drive_start;
    logic                             fire;
    logic                             adv;
    logic                             rev;
    logic                             running;
    logic [brp_pkg::NUM_RELAY-1:0]    relay;
  } brp_state_type;

  brp_state_type st;
  brp_state_type next_st;

  function automatic logic pick(input logic [1:0] sel, input logic contact, input logic net_bit,
                                input logic idle);
    logic r;
    r = idle;
    if (sel == brp_pkg::SRC_CONTACT) begin
      r = contact;
    end else if (sel == brp_pkg::SRC_NET) begin
      r = net_bit;
    end
    return r;
  endfunction : pick

  logic [brp_pkg::NUM_FN-1:0] raw_fn;
  logic [brp_pkg::NUM_FN-1:0] idle_fn;
  logic [brp_pkg::NUM_FN-1:0] eff;
  logic                       start_in;
  logic                       permit;
  logic                       ilock_ok;
  logic                       reset_in;
  logic                       start_req;
  logic                       line_run_req;
  logic                       drive_run_req;
  logic                       line_fault_any;
  logic                       sys_fault;
  logic                       line_running;
  logic [31:0]                rdata;
  logic                       mapped;
  logic [31:0]                fn_vec;
  logic                       setup;
  logic                       wr;

  always_comb begin
    raw_fn = {st.c_sync.adv_ovr, st.c_sync.fault_reset, st.c_sync.interlock, st.c_sync.permit,
              st.c_sync.start};
    // An ignored permissive or interlock must not block the motor, so it idles closed.
    idle_fn = 5'h06;
    for (int i = 0; i < brp_pkg::NUM_FN; i++) begin
      eff[i] = pick(st.src[brp_pkg::SRC_W*i +: brp_pkg::SRC_W], raw_fn[i], st.net[i], idle_fn[i]);
    end
    start_in = eff[brp_pkg::FN_START];
    permit   = eff[brp_pkg::FN_PERMIT];
    ilock_ok = eff[brp_pkg::FN_ILOCK];
    reset_in = eff[brp_pkg::FN_RESET];
  end

  always_comb begin
    line_fault_any = st.line_flt | st.ovld;
    sys_fault      = line_fault_any | st.k_sync.drive_fault;
    drive_run_req  = !st.line_mode && st.drive_auto && start_in;
    line_run_req   = st.line_mode && ((st.ctl == brp_pkg::CTL_HAND) ||
                                      ((st.ctl == brp_pkg::CTL_AUTO) && start_in));
    start_req      = drive_run_req | line_run_req;
    line_running   = st.drv.line_contactor;
  end

  always_comb begin
    fn_vec = 32'h0000_0000;
    fn_vec[brp_pkg::RF_READY]     = ilock_ok && (st.line_mode ? !line_fault_any
                                                              : !st.k_sync.drive_fault);
    fn_vec[brp_pkg::RF_RUNNING]   = st.running;
    fn_vec[brp_pkg::RF_STARTED]   = start_req && ilock_ok && !sys_fault;
    fn_vec[brp_pkg::RF_LINE_SEL]  = st.line_mode;
    fn_vec[brp_pkg::RF_LINE_RUN]  = line_running;
    fn_vec[brp_pkg::RF_LINE_FLT]  = line_fault_any;
    fn_vec[brp_pkg::RF_LINE_OK]   = st.k_sync.power_ok && !line_fault_any;
    fn_vec[brp_pkg::RF_LINE_WARN] = st.k_sync.line_warn;
    fn_vec[brp_pkg::RF_DRV_FLT]   = st.k_sync.drive_fault;
    fn_vec[brp_pkg::RF_DRV_OK]    = st.k_sync.power_ok && !st.k_sync.drive_fault;
    fn_vec[brp_pkg::RF_DRV_WARN]  = st.k_sync.drive_warn;
    fn_vec[brp_pkg::RF_OVERRIDE]  = st.fire | st.adv;
    fn_vec[brp_pkg::RF_LINE_HAND] = line_running && (st.ctl == brp_pkg::CTL_HAND);
    fn_vec[brp_pkg::RF_LINE_OFF]  = (st.ctl == brp_pkg::CTL_OFF);
    fn_vec[brp_pkg::RF_LINE_AUTO] = (st.ctl == brp_pkg::CTL_AUTO);
    fn_vec[brp_pkg::RF_NET_CTRL]  = st.comm_relay;
    fn_vec[brp_pkg::RF_ANY_WARN]  = st.k_sync.drive_warn | st.k_sync.line_warn;
    fn_vec[brp_pkg::RF_LINE_FW]   = line_fault_any | st.k_sync.line_warn;
  end

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    unique case (I_PADDR)
      brp_pkg::ADDR_SRC: begin
        rdata[9:0] = st.src;
      end
      brp_pkg::ADDR_NETCMD: begin
        rdata[4:0]                  = st.net;
        rdata[brp_pkg::NET_RELAY_ST] = st.comm_relay;
      end
      brp_pkg::ADDR_MODE: begin
        rdata[brp_pkg::MODE_LINE]                = st.line_mode;
        rdata[brp_pkg::MODE_DRV_AUTO]            = st.drive_auto;
        rdata[brp_pkg::MODE_CTL_LSB +: 2]        = st.ctl;
      end
      brp_pkg::ADDR_RELSEL: begin
        rdata[24:0] = st.relsel;
      end
      brp_pkg::ADDR_STATUS: begin
        // Contacts are reported whatever their source setting.
        rdata[brp_pkg::ST_CONTACT_LSB +: 7] = st.c_sync;
        rdata[brp_pkg::ST_RELAY_LSB +: 5]   = st.relay;
        rdata[brp_pkg::ST_FLAG_LSB +: 8]    = {st.rev, st.adv, st.fire, st.running,
                                               (st.lock_cnt != '0), st.ovld, st.line_flt, st.flash};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    setup   = I_PSEL && !I_PENABLE && I_CE;
    wr      = I_PSEL && I_PENABLE && I_PWRITE && I_CE && !st.pslverr;
    next_st = st;
    next_st.c_meta = I_CONTACT;
    next_st.c_sync = st.c_meta;
    next_st.k_meta = I_COND;
    next_st.k_sync = st.k_meta;

    // Read data and the error answer are prepared in the setup cycle.
    if (setup) begin
      next_st.prdata  = (mapped && !I_PWRITE) ? rdata : 32'h0000_0000;
      next_st.pslverr = !mapped || (I_PWRITE && (I_PADDR == brp_pkg::ADDR_STATUS));
    end
    if (wr) begin
      unique case (I_PADDR)
        brp_pkg::ADDR_SRC: begin
          next_st.src = I_PWDATA[9:0];
        end
        brp_pkg::ADDR_NETCMD: begin
          next_st.net = I_PWDATA[4:0];
          if (I_PWDATA[brp_pkg::NET_RELAY_OFF]) begin
            next_st.comm_relay = 1'b0;
          end
          if (I_PWDATA[brp_pkg::NET_RELAY_ON]) begin
            next_st.comm_relay = 1'b1;
          end
        end
        brp_pkg::ADDR_MODE: begin
          next_st.line_mode  = I_PWDATA[brp_pkg::MODE_LINE];
          next_st.drive_auto = I_PWDATA[brp_pkg::MODE_DRV_AUTO];
          next_st.ctl        = brp_pkg::brp_ctl_type'(I_PWDATA[brp_pkg::MODE_CTL_LSB +: 2]);
        end
        brp_pkg::ADDR_RELSEL: begin
          next_st.relsel = I_PWDATA[24:0];
        end
        default: begin
        end
      endcase
    end

    // Overload lockout: reset stays refused until the lockout timer has run out.
    next_st.reset_prev = reset_in;
    if (st.lock_cnt != '0) begin
      next_st.lock_cnt = st.lock_cnt - 1'b1;
    end
    if (reset_in && !st.reset_prev && (st.lock_cnt == '0)) begin
      next_st.line_flt = 1'b0;
      next_st.ovld     = 1'b0;
    end
    // A fault arriving with the reset edge wins over the clear.
    if (st.k_sync.line_fault) begin
      next_st.line_flt = 1'b1;
    end
    if (st.k_sync.overload_trip) begin
      next_st.ovld     = 1'b1;
      next_st.lock_cnt = LOCK_CYC;
    end

    // Flash timebase for the enabled indicator.
    if (st.flash_cnt == '0) begin
      next_st.flash_cnt = FLASH_CYC - 1'b1;
      next_st.flash     = !st.flash;
    end else begin
      next_st.flash_cnt = st.flash_cnt - 1'b1;
    end

    next_st.drive_start = drive_run_req && ilock_ok && permit && !st.k_sync.drive_fault;
    next_st.drv.drive_contactor = !st.line_mode && ilock_ok;
    next_st.drv.line_contactor  = line_run_req && ilock_ok && permit && !line_fault_any;
    next_st.drv.started_relay   = start_req && ilock_ok && !sys_fault;
    next_st.drv.led_red         = !ilock_ok;
    if (!ilock_ok) begin
      next_st.drv.led_green = 1'b0;
    end else if (start_req && !permit) begin
      next_st.drv.led_green = st.flash;
    end else begin
      next_st.drv.led_green = 1'b1;
    end
    next_st.running = st.drv.line_contactor ||
                      (st.drv.drive_contactor && st.k_sync.drive_running);

    next_st.adv  = eff[brp_pkg::FN_ADV];
    next_st.fire = st.c_sync.smoke;
    next_st.rev  = st.c_sync.reverse;

    // Codes outside 1 to 18 index zero bits of the function vector.
    for (int r = 0; r < brp_pkg::NUM_RELAY; r++) begin
      next_st.relay[r] = fn_vec[st.relsel[brp_pkg::SEL_W*r +: brp_pkg::SEL_W]];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      st        <= '0;
      st.src    <= brp_pkg::SRC_RST;
      st.net    <= brp_pkg::NET_RST;
      st.relsel <= brp_pkg::RELSEL_RST;
      st.ctl    <= brp_pkg::CTL_OFF;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  assign O_PRDATA       = st.prdata;
  assign O_PREADY       = I_PSEL && I_PENABLE && I_CE;
  assign O_PSLVERR      = I_PSEL && I_PENABLE && st.pslverr;
  assign O_DRIVE        = st.drv;
  assign O_DRIVE_START  = st.drive_start;
  assign O_FIRE_MODE    = st.fire;
  assign O_ADV_MODE     = st.adv;
  assign O_REVERSE_MODE = st.rev;
  assign O_RELAY        = st.relay;

endmodule : brp_relay_io

// *** tb/brp_relay_io_assertions.sv ***
`timescale 1ns/10ps
module brp_relay_io_assertions (
  // Clock, reset, enable.
  input wire logic                     I_CLK_SYS,
  input wire logic                     I_NRST,
  input wire logic                     I_CE,
  // APB.
  input wire logic                     I_PSEL,
  input wire logic                     I_PENABLE,
  input wire logic                     I_PWRITE,
  input wire logic [7:0]               I_PADDR,
  input wire logic [31:0]              O_PRDATA,
  input wire logic                     O_PREADY,
  input wire logic                     O_PSLVERR,
  // Contacts and drive.
  input wire brp_pkg::brp_contact_type I_CONTACT,
  input wire brp_pkg::brp_drive_type   O_DRIVE,
  input wire logic                     O_FIRE_MODE,
  input wire logic                     O_REVERSE_MODE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);

  AST_PREADY: assert property (O_PREADY == (I_PSEL && I_PENABLE && I_CE))
    else $error("ready does not follow the access phase");
  AST_ERR_UNMAPPED: assert property (I_PSEL && I_PENABLE && I_CE && I_PADDR > 8'h10 |-> O_PSLVERR)
    else $error("unmapped access without error");
  AST_ERR_STATUS_WR: assert property (I_PSEL && I_PENABLE && I_CE && I_PWRITE &&
                                      I_PADDR == brp_pkg::ADDR_STATUS |-> O_PSLVERR)
    else $error("status write without error");
  AST_MAPPED_OK: assert property (I_PSEL && I_PENABLE && I_PADDR == brp_pkg::ADDR_MODE |-> !O_PSLVERR)
    else $error("mode access flagged as error");
  AST_ERR_DATA: assert property (O_PREADY && O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("error read returns data");
  // Read data is only captured in a setup cycle, so it must hold across anything else.
  AST_PRDATA_HOLD: assert property (!(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA))
    else $error("read data moved outside a setup cycle");
  AST_RED_DROPS: assert property (O_DRIVE.led_red |->
                                  !O_DRIVE.line_contactor && !O_DRIVE.drive_contactor && !O_DRIVE.started_relay)
    else $error("contactor closed while interlock red");
  AST_FIRE: assert property ($stable(I_CONTACT.smoke) [*5] |-> O_FIRE_MODE == I_CONTACT.smoke)
    else $error("fire mode does not follow smoke contact");
  AST_REVERSE: assert property (I_CONTACT.reverse [*6] |-> O_REVERSE_MODE)
    else $error("reverse mode not selected");

  cover property (O_FIRE_MODE);
  cover property (O_DRIVE.led_red);
  cover property (O_PREADY && O_PSLVERR);
endmodule : brp_relay_io_assertions

bind brp_relay_io brp_relay_io_assertions brp_relay_io_assertions_i (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_CE(I_CE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_CONTACT(I_CONTACT), .O_DRIVE(O_DRIVE), .O_FIRE_MODE(O_FIRE_MODE), .O_REVERSE_MODE(O_REVERSE_MODE));

// *** tb/brp_plant_model.sv ***
`timescale 1ns/10ps
module brp_plant_model (
  // Clock.
  input  wire logic                     i_clk,
  // Requested contact and plant state.
  input  wire brp_pkg::brp_contact_type i_contact,
  input  wire brp_pkg::brp_cond_type    i_cond,
  // Lines toward the board.
  output brp_pkg::brp_contact_type      o_contact,
  output brp_pkg::brp_cond_type         o_cond
);
  // Dry contacts are asynchronous; moving them just after an edge keeps the bench free of races.
  always @(posedge i_clk) begin
    o_contact <= i_contact;
    o_cond    <= i_cond;
  end
endmodule : brp_plant_model

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic                     clk;
  logic                     nrst;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [7:0]               paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  brp_pkg::brp_contact_type ct;
  brp_pkg::brp_contact_type contact;
  brp_pkg::brp_cond_type    cd;
  brp_pkg::brp_cond_type    cond;
  brp_pkg::brp_drive_type   drv;
  logic                     drv_start;
  logic                     fire;
  logic                     adv;
  logic                     rev;
  logic [4:0]               relay;
  logic [31:0]              rd;
  logic                     err;
  int                       miscompares;
  int                       n_checks;

  brp_plant_model brp_plant_model_i (.i_clk(clk), .i_contact(ct), .i_cond(cd), .o_contact(contact), .o_cond(cond));
  brp_relay_io #(.FLASH_CYC(26'h000_0004), .LOCK_CYC(36'h0_0000_00c8)) brp_relay_io_i (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_CONTACT(contact), .I_COND(cond), .O_DRIVE(drv), .O_DRIVE_START(drv_start), .O_FIRE_MODE(fire),
    .O_ADV_MODE(adv), .O_REVERSE_MODE(rev), .O_RELAY(relay));

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task settle;
    repeat (6) @(posedge clk);
  endtask : settle

  task setio(input brp_pkg::brp_contact_type c, input brp_pkg::brp_cond_type k);
    @(posedge clk);
    ct <= c;
    cd <= k;
    repeat (8) @(posedge clk);
  endtask : setio

  task sel(input logic [4:0] code);
    xfer(brp_pkg::ADDR_RELSEL, 1'b1, {7'h00, {5{code}}});
    settle();
  endtask : sel

  task t_reset;
    for (int i = 0; i < 4; i++) begin
      xfer(8'(4 * i), 1'b0, 32'h0);
      chk("reset value", 32'h0, rd);
    end
    chk("relays after reset", 32'h0, relay);
    xfer(8'h20, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    xfer(brp_pkg::ADDR_STATUS, 1'b1, 32'hffff_ffff);
    chk("status write error", 32'h1, err);
    $display("test reset done");
  endtask : t_reset

  task t_codes;
    logic [17:0] tbl;
    logic        exp;
    for (int p = 0; p < 2; p++) begin
      tbl = p ? 18'h0_2140 : 18'h3_42df;
      xfer(brp_pkg::ADDR_MODE, 1'b1, p ? 32'h0000_0002 : 32'h0000_0021);
      setio(7'h07, p ? 7'h41 : 7'h50);
      if (p == 0) chk("line contactor", 32'h1, drv.line_contactor);
      for (int c = 0; c < 32; c++) begin
        exp = (c >= 1 && c <= 18) ? tbl[c-1] : 1'b0;
        sel(5'(c));
        if (c < 8) begin
          chk("relay function", {27'h0, {5{exp}}}, relay);
        end else if (c < 13) begin
          chk("relay function", {27'h0, {5{exp}}}, relay);
        end else begin
          chk("relay function", {27'h0, {5{exp}}}, relay);
        end
      end
    end
    $display("test codes done");
  endtask : t_codes

  task t_source;
    xfer(brp_pkg::ADDR_MODE, 1'b1, 32'h0000_0021);
    sel(brp_pkg::RF_STARTED);
    xfer(brp_pkg::ADDR_SRC, 1'b1, 32'h0000_0002);
    xfer(brp_pkg::ADDR_NETCMD, 1'b1, 32'h0000_0001);
    setio(7'h06, 7'h40);
    chk("network start", 32'h1f, relay);
    xfer(brp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("contacts reported", 32'h06, rd[6:0]);
    xfer(brp_pkg::ADDR_NETCMD, 1'b1, 32'h0);
    settle();
    chk("network stop", 32'h0, relay);
    xfer(brp_pkg::ADDR_SRC, 1'b1, 32'h0000_0001);
    setio(7'h07, 7'h40);
    chk("ignored start", 32'h0, relay);
    xfer(brp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("ignored contact reported", 32'h07, rd[6:0]);
    xfer(brp_pkg::ADDR_SRC, 1'b1, 32'h0000_0010);
    setio(7'h03, 7'h40);
    chk("ignored interlock", 32'h1f, relay);
    xfer(brp_pkg::ADDR_SRC, 1'b1, 32'h0);
    $display("test source done");
  endtask : t_source

  task t_safety;
    logic [1:0] seen;
    setio(7'h03, 7'h40);
    chk("red lit", 32'h1, drv.led_red);
    chk("line contactor dropped", 32'h0, drv.line_contactor);
    chk("started relay dropped", 32'h0, drv.started_relay);
    chk("started function off", 32'h0, relay);
    sel(brp_pkg::RF_RUNNING);
    setio(7'h05, 7'h40);
    seen = 2'b00;
    repeat (24) begin
      @(posedge clk);
      seen = seen | {drv.led_green === 1'b1, drv.led_green === 1'b0};
    end
    chk("green flashing", 32'h3, seen);
    chk("running blocked", 32'h0, relay);
    xfer(brp_pkg::ADDR_MODE, 1'b1, 32'h0000_0002);
    setio(7'h07, 7'h40);
    chk("drive started", 32'h1, drv_start);
    chk("drive contactor closed", 32'h1, drv.drive_contactor);
    setio(7'h06, 7'h40);
    chk("drive stopped", 32'h0, drv_start);
    setio(7'h03, 7'h40);
    chk("drive contactor dropped", 32'h0, drv.drive_contactor);
    chk("drive start blocked", 32'h0, drv_start);
    $display("test safety done");
  endtask : t_safety

  task t_fault;
    xfer(brp_pkg::ADDR_MODE, 1'b1, 32'h0000_0021);
    sel(brp_pkg::RF_LINE_FLT);
    setio(7'h07, 7'h60);
    setio(7'h07, 7'h40);
    chk("overload latched", 32'h1f, relay);
    setio(7'h0f, 7'h40);
    setio(7'h07, 7'h40);
    chk("reset in lockout", 32'h1f, relay);
    repeat (250) @(posedge clk);
    setio(7'h0f, 7'h40);
    setio(7'h07, 7'h40);
    chk("reset after lockout", 32'h0, relay);
    setio(7'h07, 7'h48);
    setio(7'h07, 7'h40);
    chk("line fault latched", 32'h1f, relay);
    setio(7'h0f, 7'h40);
    setio(7'h07, 7'h40);
    chk("line fault reset", 32'h0, relay);
    $display("test fault done");
  endtask : t_fault

  task t_modes;
    sel(brp_pkg::RF_OVERRIDE);
    for (int i = 4; i < 7; i++) begin
      setio(7'h07 | 7'(1 << i), 7'h40);
      chk("mode outputs", 32'(1 << (i - 4)), {rev, fire, adv});
      chk("override relay", (i < 6) ? 32'h1f : 32'h0, relay);
    end
    setio(7'h07, 7'h40);
    sel(brp_pkg::RF_NET_CTRL);
    for (int j = 0; j < 3; j++) begin
      xfer(brp_pkg::ADDR_NETCMD, 1'b1, (j == 2) ? 32'h0000_0200 : (j ? 32'h0000_0300 : 32'h0000_0100));
      settle();
      chk("comm relay", (j == 2) ? 32'h0 : 32'h1f, relay);
    end
    $display("test modes done");
  endtask : t_modes

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ct = '0;
    cd = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_codes();
    t_source();
    t_safety();
    t_fault();
    t_modes();
    end_of_test();
  end
endmodule : testbench
